// File: rtl/art_regs.sv
// Result, threshold and bank comparator registers of the telemetry controller.
// Assumes host accesses arrive as one-cycle requests synchronous to clk.
`timescale 1ns/1ns
`include "art_defines.svh"

module art_regs
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Host register port
  input wire art_pkg::art_req_s reg_req,
  output logic [7:0] reg_rdata,
  // Converter side
  input wire logic conv_start,
  input wire logic [11:0] conv_value,
  // Bank comparator inputs
  input wire art_pkg::art_level_t bank_level,
  // Analog controls
  output logic [7:0] dac_code,
  output logic [7:0] bank_select
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic addr_hit(input logic [4:0] addr, input logic [4:0] target);
    addr_hit = (addr == target);
  endfunction : addr_hit

  // ****************************************
  // State
  // ****************************************
  art_pkg::art_conv_e conv_q;
  art_pkg::art_conv_e conv_d;
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [11:0] result_q;
  logic [11:0] result_d;
  logic [7:0] thresh_q;
  logic [7:0] thresh_d;
  logic [7:0] select_q;
  logic [7:0] select_d;
  logic [7:0] cmp_q;
  logic [7:0] cmp_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic load;

  // ****************************************
  // Conversion edge counter and result load
  // ****************************************
  // The converter value is taken as a whole word, so the two halves never mix
  assign load = (conv_q == art_pkg::CONV_BUSY) && (cnt_q == (`ART_LOAD_EDGE - `ART_CNT_ONE));

  always_comb
  begin
    conv_d = conv_q;
    cnt_d = cnt_q;
    result_d = result_q;
    case (conv_q)
      art_pkg::CONV_IDLE:
      begin
        if (conv_start)
        begin
          conv_d = art_pkg::CONV_BUSY;
          cnt_d = `ART_CNT_ZERO;
        end
      end
      art_pkg::CONV_BUSY:
      begin
        // A start during a conversion is ignored
        cnt_d = cnt_q + `ART_CNT_ONE;
        if (load)
        begin
          result_d = conv_value;
          conv_d = art_pkg::CONV_IDLE;
          cnt_d = `ART_CNT_ZERO;
        end
      end
      default:
      begin
        conv_d = art_pkg::CONV_IDLE;
        cnt_d = `ART_CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      conv_q <= art_pkg::CONV_IDLE;
      cnt_q <= `ART_CNT_ZERO;
      result_q <= `ART_RESET_RESULT;
    end
    else
    begin
      conv_q <= conv_d;
      cnt_q <= cnt_d;
      result_q <= result_d;
    end
  end

  // ****************************************
  // Writable registers and read port
  // ****************************************
  // Writes to 9, 10 and 13 fall through and change nothing
  always_comb
  begin
    thresh_d = thresh_q;
    select_d = select_q;
    rdata_d = rdata_q;
    if (reg_req.wr && addr_hit(reg_req.addr, `ART_ADDR_THRESH))
    begin
      thresh_d = reg_req.wdata;
    end
    if (reg_req.wr && addr_hit(reg_req.addr, `ART_ADDR_SELECT))
    begin
      select_d = reg_req.wdata;
    end
    if (reg_req.rd)
    begin
      // Reads only load the read latch, nothing else moves
      if (addr_hit(reg_req.addr, `ART_ADDR_RES_HIGH))
      begin
        rdata_d = result_q[`ART_RES_HIGH_TOP:`ART_RES_HIGH_BOT];
      end
      else if (addr_hit(reg_req.addr, `ART_ADDR_RES_LOW))
      begin
        rdata_d = {`ART_LOW_PAD, result_q[`ART_RES_LOW_TOP:`ART_RES_LOW_BOT]};
      end
      else if (addr_hit(reg_req.addr, `ART_ADDR_THRESH))
      begin
        rdata_d = thresh_q;
      end
      else if (addr_hit(reg_req.addr, `ART_ADDR_SELECT))
      begin
        rdata_d = select_q;
      end
      else if (addr_hit(reg_req.addr, `ART_ADDR_CMP))
      begin
        rdata_d = cmp_q;
      end
      else
      begin
        rdata_d = `ART_UNMAPPED_BYTE;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      thresh_q <= `ART_RESET_BYTE;
      select_q <= `ART_RESET_BYTE;
      rdata_q <= `ART_RESET_BYTE;
    end
    else
    begin
      thresh_q <= thresh_d;
      select_q <= select_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // Bank comparators
  // ****************************************
  // Digital stand-in for the analog comparators; hysteresis rounded down to whole codes
  localparam logic [8:0] HYST = 9'(`ART_HYST_CODES);

  generate
    for (genvar i = 0; i < 8; i++)
    begin : g_cmp
      always_comb
      begin
        cmp_d[i] = (bank_level[i] > thresh_q) ||
                   (cmp_q[i] && (({1'b0, bank_level[i]} + HYST) >= {1'b0, thresh_q}));
      end

      a_cmp_rise: assert property (@(posedge clk) disable iff (!rst_b)
        (bank_level[i] > thresh_q) |=> cmp_q[i])
        else $error("comparator missed a level above threshold");

      a_cmp_hyst: assert property (@(posedge clk) disable iff (!rst_b)
        (cmp_q[i] && (({1'b0, bank_level[i]} + HYST) >= {1'b0, thresh_q})) |=> cmp_q[i])
        else $error("comparator fell inside the hysteresis band");

      a_cmp_fall: assert property (@(posedge clk) disable iff (!rst_b)
        ((({1'b0, bank_level[i]} + HYST) < {1'b0, thresh_q})) |=> !cmp_q[i])
        else $error("comparator stayed high below falling level");
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cmp_q <= `ART_RESET_BYTE;
    end
    else
    begin
      cmp_q <= cmp_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = rdata_q;
  // Code reaches the DAC unchanged; its transfer is code / 51 volts
  assign dac_code = thresh_q;
  assign bank_select = select_q;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_start_idle;
    (conv_q == art_pkg::CONV_IDLE) && conv_start;
  endsequence

  sequence s_load_done;
    ##40 (result_q == $past(conv_value));
  endsequence

  // Old value must still stand on the edge that loads the new one
  sequence s_old_kept;
    ##39 (result_q == $past(result_q, 39));
  endsequence

  a_load_edge: assert property (@(posedge clk) disable iff (!rst_b)
    s_start_idle |-> s_load_done)
    else $error("result not loaded on the 39th edge");

  a_hold_busy: assert property (@(posedge clk) disable iff (!rst_b)
    ((conv_q == art_pkg::CONV_BUSY) && !load) |=> $stable(result_q))
    else $error("result changed before the conversion completed");

  a_high_read: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_req.rd && (reg_req.addr == `ART_ADDR_RES_HIGH))
      |=> (reg_rdata == $past(result_q[`ART_RES_HIGH_TOP:`ART_RES_HIGH_BOT])))
    else $error("high result read mismatch");

  a_low_read: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_req.rd && (reg_req.addr == `ART_ADDR_RES_LOW))
      |=> (reg_rdata[3:0] == $past(result_q[`ART_RES_LOW_TOP:`ART_RES_LOW_BOT])))
    else $error("low result read mismatch");

  a_low_pad: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_req.rd && (reg_req.addr == `ART_ADDR_RES_LOW)) |=> (reg_rdata[7:4] == `ART_LOW_PAD))
    else $error("low result upper nibble not zero");

  a_reset_clear: assert property (@(posedge clk)
    !rst_b |=> ((result_q == `ART_RESET_RESULT) && (dac_code == `ART_RESET_BYTE)))
    else $error("registers not cleared by reset");

  a_thresh_wr: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_req.wr && (reg_req.addr == `ART_ADDR_THRESH)) |=> (dac_code == $past(reg_req.wdata)))
    else $error("threshold code not driven after write");

  a_select_wr: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_req.wr && (reg_req.addr == `ART_ADDR_SELECT)) |=> (bank_select == $past(reg_req.wdata)))
    else $error("selection not stored after write");

  a_ro_result: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_req.wr && !load && ((reg_req.addr == `ART_ADDR_RES_HIGH) ||
      (reg_req.addr == `ART_ADDR_RES_LOW))) |=> $stable(result_q))
    else $error("write changed a read-only result");

  a_keep_old: assert property (@(posedge clk) disable iff (!rst_b)
    s_start_idle |-> s_old_kept)
    else $error("result replaced before the 39th edge");

  a_start_ignore: assert property (@(posedge clk) disable iff (!rst_b)
    ((conv_q == art_pkg::CONV_BUSY) && conv_start && !load)
      |=> ((conv_q == art_pkg::CONV_BUSY) && (cnt_q == ($past(cnt_q) + `ART_CNT_ONE))))
    else $error("start during a conversion disturbed the count");

  a_cmp_read: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_req.rd && (reg_req.addr == `ART_ADDR_CMP)) |=> (reg_rdata == $past(cmp_q)))
    else $error("comparator status read mismatch");

  a_thresh_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !(reg_req.wr && (reg_req.addr == `ART_ADDR_THRESH)) |=> $stable(dac_code))
    else $error("threshold code changed without a write");

  a_select_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !(reg_req.wr && (reg_req.addr == `ART_ADDR_SELECT)) |=> $stable(bank_select))
    else $error("selection changed without a write");

endmodule : art_regs

// File: inc/art_defines.svh
// Offsets, field positions, reset values and counts for the result/threshold register group.
// Assumes a 5-bit register address and 8-bit register data.
`ifndef ART_DEFINES_SVH
`define ART_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define ART_ADDR_RES_HIGH 5'h09
`define ART_ADDR_RES_LOW 5'h0a
`define ART_ADDR_THRESH 5'h0b
`define ART_ADDR_SELECT 5'h0c
`define ART_ADDR_CMP 5'h0d

// ****************************************
// Field positions and reset values
// ****************************************
`define ART_RES_HIGH_TOP 11
`define ART_RES_HIGH_BOT 4
`define ART_RES_LOW_TOP 3
`define ART_RES_LOW_BOT 0
`define ART_LOW_PAD 4'h0
`define ART_RESET_BYTE 8'h00
`define ART_RESET_RESULT 12'h000
`define ART_UNMAPPED_BYTE 8'h00

// ****************************************
// Timing and analog model counts
// ****************************************
`define ART_LOAD_EDGE 6'd39
`define ART_CNT_ZERO 6'h00
`define ART_CNT_ONE 6'h01
`define ART_HYST_MV 112
`define ART_CODE_PER_V 51
`define ART_HYST_CODES ((`ART_HYST_MV * `ART_CODE_PER_V) / 1000)

`endif

// File: inc/art_pkg.sv
// Types shared by the result/threshold register group.
// Assumes the constants of art_defines.svh.
package art_pkg;

  typedef enum logic {
    CONV_IDLE,
    CONV_BUSY
  } art_conv_e;

  // One register access from the host register port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } art_req_s;

  // Eight bank comparator input levels, in threshold code units
  typedef logic [7:0][7:0] art_level_t;

endpackage : art_pkg

// File: sim/art_host.sv
// Host controller model for the register port of the result/threshold group.
// Assumes it is called at a falling edge of clk; requests are taken at the next rising edge.
`timescale 1ns/1ns

module art_host
(
  // Clock
  input wire logic clk,
  // Register port
  output art_pkg::art_req_s reg_req,
  input wire logic [7:0] reg_rdata
);
  initial reg_req = '0;

  // ****************************************
  // Bus cycles
  // ****************************************
  // Idle lines show inverted last value, so a stale address never passes for a held one
  // One idle cycle follows, so no strobe is rewritten in the same time step
  task automatic go_idle;
    reg_req.wr = 1'b0;
    reg_req.rd = 1'b0;
    reg_req.addr = ~reg_req.addr;
    reg_req.wdata = ~reg_req.wdata;
    @(negedge clk);
  endtask : go_idle

  task automatic write_reg(input logic [4:0] a, input logic [7:0] v);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge clk);
    go_idle();
  endtask : write_reg

  task automatic read_reg(input logic [4:0] a, output logic [7:0] v);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: reg_req.wdata};
    @(negedge clk);
    v = reg_rdata;
    go_idle();
  endtask : read_reg
endmodule : art_host

// File: sim/testbench.sv
// Self-checking bench for the result/threshold register group.
// Assumes the host model drives the register port; the bench drives converter and levels.
`timescale 1ns/1ns

module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  art_pkg::art_req_s reg_req;
  logic [7:0] reg_rdata;
  logic [7:0] dac_code;
  logic [7:0] bank_select;
  logic [7:0] d;
  logic conv_start = 1'b0;
  logic [11:0] conv_value = 12'h000;
  art_pkg::art_level_t bank_level = '0;
  int n_errors = 0;
  int comparisons = 0;

  initial
  begin
    forever #50 clk = ~clk;
  end

  art_regs i_dut (.clk(clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .conv_start(conv_start), .conv_value(conv_value), .bank_level(bank_level),
    .dac_code(dac_code), .bank_select(bank_select));
  art_host i_host (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    i_host.read_reg(a, d);
    check(d, exp);
  endtask : rd

  task automatic results;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset;
    for (int a = 9; a <= 13; a++)
      rd(a[4:0], 8'h00);
    check(dac_code, 8'h00);
    check(bank_select, 8'h00);
  endtask : test_reset

  task automatic test_thresh;
    i_host.write_reg(5'h0b, 8'ha5);
    check(dac_code, 8'ha5);
    rd(5'h0b, 8'ha5);
    i_host.write_reg(5'h0c, 8'h3c);
    check(bank_select, 8'h3c);
    rd(5'h0c, 8'h3c);
    i_host.write_reg(5'h0d, 8'hff);
    rd(5'h0d, 8'h00);
    rd(5'h1f, 8'h00);
  endtask : test_thresh

  // A second start while busy must not restart the count
  task automatic test_conv;
    conv_value = 12'h123;
    conv_start = 1'b1;
    @(negedge clk);
    conv_start = 1'b0;
    for (int i = 1; i <= 38; i++)
    begin
      @(negedge clk);
      conv_start = (i == 10);
      conv_value = (i == 38) ? 12'habc : 12'h123;
    end
    rd(5'h09, 8'h00);
    conv_value = 12'h555;
    rd(5'h09, 8'hab);
    rd(5'h0a, 8'h0c);
    i_host.write_reg(5'h09, 8'hff);
    i_host.write_reg(5'h0a, 8'hff);
    rd(5'h09, 8'hab);
    rd(5'h0a, 8'h0c);
  endtask : test_conv

  task automatic test_cmp;
    i_host.write_reg(5'h0b, 8'h40);
    bank_level[0] = 8'h41;
    bank_level[7] = 8'h80;
    @(negedge clk);
    rd(5'h0d, 8'h81);
    bank_level[0] = 8'h3b;
    @(negedge clk);
    rd(5'h0d, 8'h81);
    bank_level[0] = 8'h3a;
    bank_level[1] = 8'h40;
    @(negedge clk);
    rd(5'h0d, 8'h80);
    bank_level = '0;
    // Unused comparators: code parked at zero to save power
    i_host.write_reg(5'h0b, 8'h00);
    check(dac_code, 8'h00);
  endtask : test_cmp

  initial
  begin
    #(3000 * 100);
    n_errors++;
    results();
  end

  initial
  begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    test_reset();
    test_thresh();
    test_conv();
    test_cmp();
    i_host.write_reg(5'h0b, 8'h77);
    check(dac_code, 8'h77);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    test_reset();
    results();
  end
endmodule : testbench
